// *** hdl/fls_force_limit_selector.sv ***
// Forward and reverse force limit selection for a linear servo drive
`timescale 1ns/100ps

// How it works
// - Analog limit only in speed or position
// - Analog magnitude limits both directions equally
// - Option one uses analog limit, after restart
// - Combined mode only with option three
// - Combined forward on: min of three limits
// - Combined forward off: internal forward only
// - Combined reverse on: min of three limits
// - Combined reverse off: internal reverse only
// - Signals sharing a terminal are ORed
// - External limits 0 to 800 percent
// - Analog reference filtered, programmable time constant
// - Status output high while force clamped
// - Analog limit scaled by input gain
// - Internal limits 0 to 800 percent
// - Settings above motor maximum use maximum
module fls_force_limit_selector #(
  parameter int SHARED_W = 2,
  parameter int CTRL_CYCLES = fls_pkg::CTRL_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control mode and option field
  input wire logic [1:0] ctrl_mode,
  input wire logic [3:0] ctrl_option_select,
  input wire logic restart_in,
  // Host limit inputs and other signals on the same terminals
  input wire logic fwd_ext_limit_in,
  input wire logic rev_ext_limit_in,
  input wire logic [SHARED_W-1:0] fwd_shared_in,
  input wire logic [SHARED_W-1:0] rev_shared_in,
  // Limit settings, percent of rated force
  input wire logic [9:0] fwd_internal_limit_setting,
  input wire logic [9:0] rev_internal_limit_setting,
  input wire logic [9:0] fwd_external_limit_setting,
  input wire logic [9:0] rev_external_limit_setting,
  input wire logic [9:0] motor_max_pct,
  // Analog limit reference and its settings
  input wire logic signed [15:0] analog_ref,
  input wire logic [15:0] ref_input_gain,
  input wire logic [15:0] ref_filter_time_const,
  // Commanded force, signed percent
  input wire logic signed [11:0] force_cmd_pct,
  // Results
  output logic [9:0] fwd_limit_q,
  output logic [9:0] rev_limit_q,
  output logic force_limited_out,
  output logic ctrl_tick_q
);

  // Refuse widths and rates the divider and filter cannot serve
  if (SHARED_W < 1 || CTRL_CYCLES < 40 || CTRL_CYCLES > 65535) begin : g_bad_params
    $error("fls_force_limit_selector: unsupported parameter values");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [9:0] min2(input logic [9:0] a, input logic [9:0] b);
    min2 = (a < b) ? a : b;
  endfunction

  // ****************************************************************
  // Control cycle tick
  // ****************************************************************
  logic [15:0] tick_cnt_q;

  // Free-running divider sets the recompute rate
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= 16'h0000;
      ctrl_tick_q <= 1'b0;
    end else if (tick_cnt_q == 16'(CTRL_CYCLES - 1)) begin
      tick_cnt_q <= 16'h0000;
      ctrl_tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      ctrl_tick_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Option field, taken at the first clock after reset and at restart
  // ****************************************************************
  // A live option change mid-motion would jump the limit, so it waits for restart.
  logic [3:0] opt_q;
  logic opt_load_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      opt_q <= 4'h0;
      opt_load_q <= 1'b1;
    end else begin
      opt_load_q <= 1'b0;
      if (opt_load_q || restart_in) begin
        opt_q <= ctrl_option_select;
      end
    end
  end

  // ****************************************************************
  // Analog limit path
  // ****************************************************************
  logic signed [15:0] ref_filt;
  logic filt_busy;

  fls_ref_filter u_filter (
    .clk(clk),
    .resetn(resetn),
    .start(ctrl_tick_q),
    .x(analog_ref),
    .tc(ref_filter_time_const),
    .y(ref_filt),
    .busy(filt_busy)
  );

  logic [15:0] ref_mag;
  logic [31:0] ref_prod;
  logic [31:0] ref_scaled;
  logic [9:0] analog_pct;

  // Sign dropped, then gain applied; the most negative code gives a magnitude of 32768
  assign ref_mag = ref_filt[15] ? 16'(-ref_filt) : ref_filt;
  assign ref_prod = ref_mag * ref_input_gain;
  assign ref_scaled = ref_prod >> fls_pkg::REF_GAIN_SHIFT;
  assign analog_pct = (ref_scaled > 32'(fls_pkg::LIMIT_MAX_PCT)) ?
                      fls_pkg::LIMIT_MAX_PCT : ref_scaled[9:0];

  // ****************************************************************
  // Limit selection
  // ****************************************************************
  logic fwd_on;
  logic rev_on;
  logic analog_ok;
  logic [9:0] max_c;
  logic [9:0] fwd_int_c;
  logic [9:0] rev_int_c;
  logic [9:0] fwd_ext_c;
  logic [9:0] rev_ext_c;
  logic [9:0] fwd_c;
  logic [9:0] rev_c;

  // Terminal level is the OR of every logical signal placed on it
  assign fwd_on = fwd_ext_limit_in | (|fwd_shared_in);
  assign rev_on = rev_ext_limit_in | (|rev_shared_in);
  assign analog_ok = ctrl_mode != fls_pkg::MODE_FORCE;
  // Settings capped at 800 percent and at the motor maximum
  assign max_c = min2(motor_max_pct, fls_pkg::LIMIT_MAX_PCT);
  assign fwd_int_c = min2(fwd_internal_limit_setting, max_c);
  assign rev_int_c = min2(rev_internal_limit_setting, max_c);
  assign fwd_ext_c = min2(fwd_external_limit_setting, max_c);
  assign rev_ext_c = min2(rev_external_limit_setting, max_c);

  // Candidate per direction from option, mode and limit inputs
  always_comb begin
    fwd_c = fwd_int_c;
    rev_c = rev_int_c;
    if (opt_q == fls_pkg::OPT_ANALOG_LIMIT && analog_ok) begin
      fwd_c = min2(fwd_int_c, analog_pct);
      rev_c = min2(rev_int_c, analog_pct);
    end else if (opt_q == fls_pkg::OPT_EXT_ANALOG && analog_ok) begin
      fwd_c = fwd_on ? min2(analog_pct, min2(fwd_int_c, fwd_ext_c)) : fwd_int_c;
      rev_c = rev_on ? min2(analog_pct, min2(rev_int_c, rev_ext_c)) : rev_int_c;
    end else if (opt_q != fls_pkg::OPT_ANALOG_LIMIT) begin
      fwd_c = fwd_on ? min2(fwd_int_c, fwd_ext_c) : fwd_int_c;
      rev_c = rev_on ? min2(rev_int_c, rev_ext_c) : rev_int_c;
    end
  end

  // ****************************************************************
  // Registered results, updated once per control cycle
  // ****************************************************************
  logic clamp_c;

  assign clamp_c = (!force_cmd_pct[11] && force_cmd_pct > $signed({2'b00, fwd_c})) ||
                   (force_cmd_pct[11] && -force_cmd_pct > $signed({2'b00, rev_c}));

  // Limits held between ticks so the force loop sees a stable clamp
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fwd_limit_q <= fls_pkg::INT_LIMIT_RESET;
      rev_limit_q <= fls_pkg::INT_LIMIT_RESET;
      force_limited_out <= 1'b0;
    end else if (ctrl_tick_q) begin
      fwd_limit_q <= fwd_c;
      rev_limit_q <= rev_c;
      force_limited_out <= clamp_c;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_tick_gap;
    !ctrl_tick_q [*8];
  endsequence

  property p_tick_gap;
    @(posedge clk) disable iff (!resetn) ctrl_tick_q |=> s_tick_gap;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("control tick too frequent");

  property p_force_mode;
    @(posedge clk) disable iff (!resetn)
    (ctrl_tick_q && !analog_ok && opt_q == fls_pkg::OPT_ANALOG_LIMIT)
      |=> fwd_limit_q == $past(fwd_int_c) && rev_limit_q == $past(rev_int_c);
  endproperty
  a_force_mode: assert property (p_force_mode) else $error("analog limit used in force mode");

  property p_opt_hold;
    @(posedge clk) disable iff (!resetn)
    (!restart_in && !opt_load_q) |=> $stable(opt_q);
  endproperty
  a_opt_hold: assert property (p_opt_hold) else $error("option changed without restart");

  property p_fwd_on;
    @(posedge clk) disable iff (!resetn)
    (ctrl_tick_q && analog_ok && opt_q == fls_pkg::OPT_EXT_ANALOG && fwd_on)
      |=> fwd_limit_q <= $past(analog_pct) && fwd_limit_q <= $past(fwd_ext_c)
          && fwd_limit_q <= $past(fwd_int_c);
  endproperty
  a_fwd_on: assert property (p_fwd_on) else $error("combined forward limit not smallest");

  property p_fwd_off;
    @(posedge clk) disable iff (!resetn)
    (ctrl_tick_q && analog_ok && opt_q == fls_pkg::OPT_EXT_ANALOG && !fwd_on)
      |=> fwd_limit_q == $past(fwd_int_c);
  endproperty
  a_fwd_off: assert property (p_fwd_off) else $error("forward limit not internal");

  property p_rev_on;
    @(posedge clk) disable iff (!resetn)
    (ctrl_tick_q && analog_ok && opt_q == fls_pkg::OPT_EXT_ANALOG && rev_on)
      |=> rev_limit_q <= $past(analog_pct) && rev_limit_q <= $past(rev_ext_c)
          && rev_limit_q <= $past(rev_int_c);
  endproperty
  a_rev_on: assert property (p_rev_on) else $error("combined reverse limit not smallest");

  property p_rev_off;
    @(posedge clk) disable iff (!resetn)
    (ctrl_tick_q && analog_ok && opt_q == fls_pkg::OPT_EXT_ANALOG && !rev_on)
      |=> rev_limit_q == $past(rev_int_c);
  endproperty
  a_rev_off: assert property (p_rev_off) else $error("reverse limit not internal");

  property p_shared;
    @(posedge clk) disable iff (!resetn)
    (ctrl_tick_q && opt_q == 4'h0 && fwd_shared_in != '0)
      |=> fwd_limit_q <= $past(fwd_ext_c);
  endproperty
  a_shared: assert property (p_shared) else $error("shared terminal signal ignored");

  property p_cap;
    @(posedge clk) disable iff (!resetn)
    ctrl_tick_q |=> fwd_limit_q <= $past(max_c) && rev_limit_q <= $past(max_c);
  endproperty
  a_cap: assert property (p_cap) else $error("limit above motor maximum");

  property p_clamp_flag;
    @(posedge clk) disable iff (!resetn)
    (ctrl_tick_q && !force_cmd_pct[11] && force_cmd_pct > $signed({2'b00, fwd_c}))
      |=> force_limited_out [*8];
  endproperty
  a_clamp_flag: assert property (p_clamp_flag) else $error("limited status not shown");

endmodule

// *** hdl/fls_ref_filter.sv ***
// Force limit selector constants and the analog limit reference low-pass filter
`timescale 1ns/100ps

package fls_pkg;
  // Clock and control cycle
  localparam int CLK_PERIOD_NS = 8;
  localparam int CTRL_PERIOD_US_X100 = 1;
  localparam int CTRL_PERIOD_NS = CTRL_PERIOD_US_X100 * 10000;
  localparam int CTRL_CYCLES = (CTRL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Limit settings, percent of rated force, and filter time constant reset
  localparam int PCT_W = 10;
  localparam logic [9:0] LIMIT_MAX_PCT = 10'h320;
  localparam logic [9:0] EXT_LIMIT_RESET = 10'h064;
  localparam logic [9:0] INT_LIMIT_RESET = 10'h320;
  localparam logic [15:0] FILTER_TC_RESET = 16'h0000;
  // Analog scaling: percent = |ref| * gain >> shift
  localparam int REF_GAIN_SHIFT = 12;
  // Control-option field values
  localparam logic [3:0] OPT_ANALOG_LIMIT = 4'h1;
  localparam logic [3:0] OPT_EXT_ANALOG = 4'h3;
  // Control mode input encoding
  localparam logic [1:0] MODE_SPEED = 2'h0;
  localparam logic [1:0] MODE_POSITION = 2'h1;
  localparam logic [1:0] MODE_FORCE = 2'h2;
  // Filter sequencer states
  typedef enum logic [1:0] {
    FLS_F_IDLE = 2'b01,
    FLS_F_DIV = 2'b10
  } fls_fstate_t;
endpackage

module fls_ref_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Sample request and settings
  input wire logic start,
  input wire logic signed [15:0] x,
  input wire logic [15:0] tc,
  // Filtered reference
  output logic signed [15:0] y,
  output logic busy
);

  // ****************************************************************
  // First-order filter, y += (x - y) / (tc + 1) per control cycle
  // ****************************************************************
  // The accumulator keeps 16 fraction bits so long time constants still creep.
  fls_pkg::fls_fstate_t st_q;
  logic signed [31:0] acc_q;
  logic [17:0] rem_q;
  logic [31:0] quo_q;
  logic [16:0] div_q;
  logic [5:0] cnt_q;
  logic neg_q;
  logic signed [32:0] diff;
  logic [17:0] rem_sh;

  assign diff = {x[15], x, 16'h0000} - {acc_q[31], acc_q};
  assign rem_sh = {rem_q[16:0], quo_q[31]};

  // Sequencer and serial restoring divider
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= fls_pkg::FLS_F_IDLE;
      acc_q <= 32'sh00000000;
      rem_q <= 18'h00000;
      quo_q <= 32'h00000000;
      div_q <= 17'h00000;
      cnt_q <= 6'h00;
      neg_q <= 1'b0;
    end else begin
      unique case (st_q)
        fls_pkg::FLS_F_IDLE: begin
          if (start && tc == 16'h0000) begin
            acc_q <= {x, 16'h0000};
          end else if (start) begin
            neg_q <= diff[32];
            quo_q <= diff[32] ? 32'(-diff) : diff[31:0];
            rem_q <= 18'h00000;
            div_q <= {1'b0, tc} + 17'h00001;
            cnt_q <= 6'h20;
            st_q <= fls_pkg::FLS_F_DIV;
          end
        end
        fls_pkg::FLS_F_DIV: begin
          if (cnt_q == 6'h00) begin
            acc_q <= neg_q ? acc_q - $signed(quo_q) : acc_q + $signed(quo_q);
            st_q <= fls_pkg::FLS_F_IDLE;
          end else begin
            cnt_q <= cnt_q - 6'h01;
            if (rem_sh >= {1'b0, div_q}) begin
              rem_q <= rem_sh - {1'b0, div_q};
              quo_q <= {quo_q[30:0], 1'b1};
            end else begin
              rem_q <= rem_sh;
              quo_q <= {quo_q[30:0], 1'b0};
            end
          end
        end
      endcase
    end
  end

  // Outputs straight from the accumulator and state flops
  assign y = acc_q[31:16];
  assign busy = st_q == fls_pkg::FLS_F_DIV;

  // Zero time constant passes the sample through at once
  property p_tc_zero;
    @(posedge clk) disable iff (!resetn)
    (start && !busy && tc == 16'h0000) |=> (y == $past(x));
  endproperty
  a_tc_zero: assert property (p_tc_zero) else $error("filter bypass missed");

  // A nonzero time constant finishes its step in 34 cycles
  property p_div_len;
    @(posedge clk) disable iff (!resetn)
    (start && !busy && tc != 16'h0000) |=> busy [*8] ##[25:27] !busy;
  endproperty
  a_div_len: assert property (p_div_len) else $error("filter step length wrong");

endmodule

// *** verif/fls_force_limit_selector_tb.sv ***
// Self-checking bench for the force limit selector
`timescale 1ns/100ps
module fls_force_limit_selector_tb;
  // ************************
  // Stimulus and observation
  // ************************
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] mode = fls_pkg::MODE_SPEED;
  logic [3:0] opt = fls_pkg::OPT_EXT_ANALOG;
  logic restart_in = 1'b0;
  logic fwd_req = 1'b0;
  logic rev_req = 1'b0;
  logic signed [15:0] ref_req = 16'sh0000;
  logic [1:0] fwd_sh = 2'h0;
  logic [1:0] rev_sh = 2'h0;
  logic [9:0] int_f = 10'h1F4;
  logic [9:0] int_r = 10'h258;
  logic [9:0] ext_f = fls_pkg::EXT_LIMIT_RESET;
  logic [9:0] ext_r = fls_pkg::EXT_LIMIT_RESET;
  logic [9:0] mmax = 10'h3FF;
  logic [15:0] gain = 16'h1000;
  logic [15:0] tc = fls_pkg::FILTER_TC_RESET;
  logic signed [11:0] cmd = 12'sh000;
  logic fwd_on;
  logic rev_on;
  logic signed [15:0] aref;
  logic [9:0] fwd_lim;
  logic [9:0] rev_lim;
  logic limited;
  logic tick;
  int n_errors = 0;
  int total_checks = 0;

  // Short control cycle keeps the run brief; the filter still fits in it
  always #4 clk = ~clk;

  fls_host_model host (.clk(clk), .fwd_req(fwd_req), .rev_req(rev_req), .ref_req(ref_req),
    .fwd_ext_limit_in(fwd_on), .rev_ext_limit_in(rev_on), .analog_ref(aref));

  fls_force_limit_selector #(.SHARED_W(2), .CTRL_CYCLES(40)) uut (.clk(clk), .resetn(resetn),
    .ctrl_mode(mode), .ctrl_option_select(opt), .restart_in(restart_in),
    .fwd_ext_limit_in(fwd_on), .rev_ext_limit_in(rev_on), .fwd_shared_in(fwd_sh),
    .rev_shared_in(rev_sh), .fwd_internal_limit_setting(int_f),
    .rev_internal_limit_setting(int_r), .fwd_external_limit_setting(ext_f),
    .rev_external_limit_setting(ext_r), .motor_max_pct(mmax), .analog_ref(aref),
    .ref_input_gain(gain), .ref_filter_time_const(tc), .force_cmd_pct(cmd),
    .fwd_limit_q(fwd_lim), .rev_limit_q(rev_lim), .force_limited_out(limited),
    .ctrl_tick_q(tick));

  // ************************
  // Shared tasks
  // ************************
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic edge1;
    @(posedge clk);
    #1;
  endtask
  // Three ticks: host lines settle, analog sample is taken, then it is used
  task automatic step;
    repeat (3) @(posedge clk iff tick);
    edge1();
  endtask
  task automatic lims(input logic [9:0] f, input logic [9:0] r);
    step();
    check("fwd_limit", {6'h00, f}, {6'h00, fwd_lim});
    check("rev_limit", {6'h00, r}, {6'h00, rev_lim});
  endtask
  task automatic restart;
    restart_in = 1'b1;
    edge1();
    restart_in = 1'b0;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ************************
  // Scenarios
  // ************************
  task automatic t_reset;
    repeat (6) @(posedge clk);
    check("reset_fwd", 16'h0320, {6'h00, fwd_lim});
    check("reset_flag", 16'h0000, {15'h0000, limited});
    #1;
    resetn = 1'b1;
    edge1();
    check("release_rev", 16'h0320, {6'h00, rev_lim});
    $display("done reset");
  endtask
  task automatic t_tick;
    int n;
    n = 1;
    @(posedge clk iff tick);
    edge1(); // First low cycle after the tick counts too
    while (tick !== 1'b1 && n < 100) begin
      edge1();
      n++;
    end
    check("tick_gap", 16'd39, n[15:0]);
    $display("done tick");
  endtask
  task automatic t_comb;
    edge1();
    fwd_req = 1'b1;
    ref_req = 16'sd200;
    ext_f = 10'h12C;
    lims(10'd200, 10'd600);
    ref_req = -16'sd700;
    rev_req = 1'b1;
    lims(10'd300, 10'd100);
    fwd_req = 1'b0;
    rev_req = 1'b0;
    lims(10'd500, 10'd600);
    fwd_sh = 2'h2;
    rev_sh = 2'h1;
    ref_req = 16'sd50;
    lims(10'd50, 10'd50);
    fwd_sh = 2'h0;
    rev_sh = 2'h0;
    $display("done combined");
  endtask
  task automatic t_mode;
    edge1();
    fwd_req = 1'b1;
    rev_req = 1'b1;
    mode = fls_pkg::MODE_FORCE;
    lims(10'd300, 10'd100);
    mode = fls_pkg::MODE_POSITION;
    gain = 16'h2000;
    ext_f = 10'h320;
    ext_r = 10'h320;
    lims(10'd100, 10'd100);
    gain = 16'h1000;
    mode = fls_pkg::MODE_SPEED;
    $display("done mode");
  endtask
  task automatic t_cap;
    edge1();
    fwd_req = 1'b0;
    mmax = 10'h0FA;
    ext_r = 10'h000;
    lims(10'd250, 10'd0);
    mmax = 10'h3FF;
    int_f = 10'h3FF;
    lims(10'd800, 10'd0);
    int_f = 10'h1F4;
    ext_r = fls_pkg::EXT_LIMIT_RESET;
    $display("done cap");
  endtask
  task automatic t_status;
    edge1();
    fwd_req = 1'b1;
    ext_f = 10'h12C;
    ref_req = 16'sd700;
    cmd = 12'sd350;
    lims(10'd300, 10'd100);
    check("flag_fwd_over", 16'h0001, {15'h0000, limited});
    cmd = 12'sd300;
    step();
    check("flag_fwd_equal", 16'h0000, {15'h0000, limited});
    cmd = -12'sd150;
    step();
    check("flag_rev_over", 16'h0001, {15'h0000, limited});
    cmd = 12'sh000;
    $display("done status");
  endtask
  task automatic t_filter;
    edge1();
    ext_f = 10'h320;
    ref_req = 16'sd200;
    lims(10'd200, 10'd100);
    tc = 16'h0001;
    ref_req = 16'sd600;
    edge1();
    edge1();
    repeat (2) @(posedge clk iff tick);
    edge1();
    check("filter_half", 16'd400, {6'h00, fwd_lim});
    @(posedge clk iff tick);
    edge1();
    check("filter_quarter", 16'd500, {6'h00, fwd_lim});
    tc = fls_pkg::FILTER_TC_RESET;
    $display("done filter");
  endtask
  task automatic t_option;
    edge1();
    fwd_req = 1'b0;
    rev_req = 1'b0;
    ref_req = 16'sd150;
    opt = fls_pkg::OPT_ANALOG_LIMIT;
    lims(10'd500, 10'd600);
    restart();
    lims(10'd150, 10'd150);
    mode = fls_pkg::MODE_FORCE;
    lims(10'd500, 10'd600);
    mode = fls_pkg::MODE_SPEED;
    // Plain external option: analog ignored, shared signal still ORed in
    opt = 4'h0;
    fwd_sh = 2'h1;
    ext_f = 10'h12C;
    rev_req = 1'b1;
    restart();
    lims(10'd300, 10'd100);
    fwd_sh = 2'h0;
    $display("done option");
  endtask

  // ************************
  // Sequence and watchdog
  // ************************
  initial begin
    t_reset();
    t_tick();
    t_comb();
    t_mode();
    t_cap();
    t_status();
    t_filter();
    t_option();
    conclude();
  end
  // Whole sequence needs about 2100 cycles; nine times that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    conclude();
  end
endmodule

// *** verif/fls_host_model.sv ***
// Host controller model driving the external limit inputs and the analog limit reference
`timescale 1ns/100ps
module fls_host_model (
  // Clock
  input wire logic clk,
  // Requests from the bench
  input wire logic fwd_req,
  input wire logic rev_req,
  input wire logic signed [15:0] ref_req,
  // Lines into the drive
  output logic fwd_ext_limit_in = 1'b0,
  output logic rev_ext_limit_in = 1'b0,
  output logic signed [15:0] analog_ref = 16'sh0000
);
  // ************************
  // Host output stage
  // ************************
  // Lines move just after the edge, so the drive never samples them mid-change
  always @(posedge clk) begin
    fwd_ext_limit_in <= #1 fwd_req;
    rev_ext_limit_in <= #1 rev_req;
    analog_ref <= #1 ref_req;
  end
endmodule
